// ---- rtl/fcs_cfg.svh ----
// Offsets, field positions, command codes and timing counts for the flash command host
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
// Register offsets (byte addresses, low 8 address bits)
`define FCS_REG_CTRL      8'h00
`define FCS_REG_ADDR      8'h04
`define FCS_REG_DATA      8'h08
`define FCS_REG_STATUS    8'h0c
`define FCS_REG_IDENT     8'h10
`define FCS_REG_IRQ_STAT  8'h14
`define FCS_REG_IRQ_MASK  8'h18
// Control register fields
`define FCS_CTRL_OP_MSB   2
`define FCS_CTRL_ALT      4
// Status register of this block: bit 8 shows an operation under way
`define FCS_STAT_BUSY     8
// Interrupt bits
`define FCS_IRQ_DONE      0
`define FCS_IRQ_FAIL      1
// Device command codes
`define FCS_CMD_READ_ARRAY 8'hff
`define FCS_CMD_IDENT      8'h90
`define FCS_CMD_STATUS     8'h70
`define FCS_CMD_CLEAR      8'h50
`define FCS_CMD_PROG       8'h40
`define FCS_CMD_PROG_ALT   8'h10
`define FCS_CMD_ERASE      8'h20
`define FCS_CMD_CONFIRM    8'hd0
`define FCS_CMD_SUSPEND    8'hb0
// Device status bit positions
`define FCS_SR_READY      7
`define FCS_SR_PAUSED     6
`define FCS_SR_ERASE_FAIL 5
`define FCS_SR_PROG_FAIL  4
`define FCS_SR_SUPPLY_LOW 3
`define FCS_SR_ERR_MASK   8'h38
`define FCS_SR_RSVD_MASK  8'hf8
// Timing: strobe widths and recovery time in ns, rounded up to whole cycles of aclk
`define FCS_CLK_NS        5
`define FCS_T_WE_NS       50
`define FCS_T_RD_NS       120
`define FCS_T_REC_NS      20
`define FCS_WE_CYC  (((`FCS_T_WE_NS) + (`FCS_CLK_NS) - 1) / (`FCS_CLK_NS))
`define FCS_RD_CYC  (((`FCS_T_RD_NS) + (`FCS_CLK_NS) - 1) / (`FCS_CLK_NS))
`define FCS_REC_CYC (((`FCS_T_REC_NS) + (`FCS_CLK_NS) - 1) / (`FCS_CLK_NS))
`endif

// ---- rtl/fcs_host.sv ----
// Host controller driving a parallel flash command decoder, with AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "fcs_cfg.svh"
module fcs_host #(
   parameter int ADDR_W = 17
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [31:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [31:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic                   irq,
   output logic [ADDR_W-1:0]      f_addr,
   output logic                   f_ce_n,
   output logic                   f_oe_n,
   output logic                   f_we_n,
   output logic [15:0]            f_dq_out,
   output logic                   f_dq_oe_n,
   input  wire logic [15:0]       f_dq_in
);
   localparam logic [7:0] WE_CYC  = 8'(`FCS_WE_CYC);
   localparam logic [7:0] RD_CYC  = 8'(`FCS_RD_CYC);
   localparam logic [7:0] REC_CYC = 8'(`FCS_REC_CYC);

   logic                aw_have;
   logic [7:0]          aw_addr;
   logic                w_have;
   logic [31:0]         w_data;
   logic [3:0]          w_strb;
   logic                wr_fire;
   logic [31:0]         addr_reg;
   logic [31:0]         data_reg;
   logic [1:0]          irq_stat;
   logic [1:0]          irq_mask;
   logic [7:0]          operation_status;
   logic [15:0]         maker_code;
   logic [15:0]         part_code;
   fcs_pkg::fcs_op_e    op;
   logic                alt_setup;
   fcs_pkg::fcs_state_e state;
   logic [1:0]          idx;
   logic [7:0]          cnt;
   fcs_pkg::fcs_step_s  step;
   logic                start;
   logic                step_end;
   logic                op_done;
   logic                op_fail;
   logic [7:0]          rd_status;
   logic [31:0]         next_rdata;
   logic                rd_mapped;

   // Merge write data into a register under the byte strobes
   function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Bus cycle list of each operation
   function automatic fcs_pkg::fcs_step_s op_step(input fcs_pkg::fcs_op_e o, input logic [1:0] i,
                                                  input logic alt);
      fcs_pkg::fcs_step_s s;
      s = '0;
      case (o)
         fcs_pkg::OP_READ_ARRAY: begin
            s.code = `FCS_CMD_READ_ARRAY;
            s.last = 1'b1;
         end
         fcs_pkg::OP_IDENT: begin
            s.code = `FCS_CMD_IDENT;
            s.rd   = (i != 2'd0);
            s.a0   = (i == 2'd2);
            s.last = (i == 2'd2);
         end
         fcs_pkg::OP_STATUS: begin
            s.code = `FCS_CMD_STATUS;
            s.rd   = (i != 2'd0);
            s.last = (i != 2'd0);
         end
         fcs_pkg::OP_CLEAR: begin
            s.code = `FCS_CMD_CLEAR;
            s.last = 1'b1;
         end
         fcs_pkg::OP_PROGRAM: begin
            s.code     = alt ? `FCS_CMD_PROG_ALT : `FCS_CMD_PROG;
            s.use_data = (i == 2'd1);
            s.rd       = (i == 2'd2);
            s.poll     = (i == 2'd2);
            s.last     = (i == 2'd2);
         end
         fcs_pkg::OP_ERASE: begin
            s.code = (i == 2'd0) ? `FCS_CMD_ERASE : `FCS_CMD_CONFIRM;
            s.rd   = (i == 2'd2);
            s.poll = (i == 2'd2);
            s.last = (i == 2'd2);
         end
         fcs_pkg::OP_SUSPEND: begin
            s.code = (i == 2'd0) ? `FCS_CMD_SUSPEND : `FCS_CMD_STATUS;
            s.rd   = (i == 2'd2);
            s.poll = (i == 2'd2);
            s.last = (i == 2'd2);
         end
         default: begin
            s.code = `FCS_CMD_CONFIRM;
            s.last = 1'b1;
         end
      endcase
      return s;
   endfunction

   // AXI write channels: address and data taken in either order
   assign s_axi_awready = !aw_have && !s_axi_bvalid;
   assign s_axi_wready  = !w_have && !s_axi_bvalid;
   assign wr_fire       = aw_have && w_have && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have <= 1'b1;
         aw_addr <= s_axi_awaddr[7:0];
      end else if (wr_fire) begin
         aw_have <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_have <= 1'b0;
      end
   end

   // Write response; unmapped offsets answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (aw_addr > `FCS_REG_IRQ_MASK || aw_addr[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Software-written registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_reg <= 32'h0000_0000;
         data_reg <= 32'h0000_ffff;
         irq_mask <= 2'h0;
      end else if (wr_fire) begin
         if (aw_addr == `FCS_REG_ADDR) addr_reg <= apply_strb(addr_reg, w_data, w_strb);
         if (aw_addr == `FCS_REG_DATA) data_reg <= apply_strb(data_reg, w_data, w_strb);
         if (aw_addr == `FCS_REG_IRQ_MASK) irq_mask <= 2'(apply_strb({30'h0, irq_mask},
                                                                    w_data, w_strb));
      end
   end

   // Control write starts an operation only when idle
   assign start = wr_fire && aw_addr == `FCS_REG_CTRL && w_strb[0] && state == fcs_pkg::ST_IDLE;

   // AXI read channel
   always_comb begin
      next_rdata = 32'h0000_0000;
      rd_mapped  = 1'b1;
      case (s_axi_araddr[7:0])
         `FCS_REG_CTRL:     next_rdata = {27'h0, alt_setup, 1'b0, op};
         `FCS_REG_ADDR:     next_rdata = addr_reg;
         `FCS_REG_DATA:     next_rdata = data_reg;
         `FCS_REG_STATUS:   next_rdata = {23'h0, state != fcs_pkg::ST_IDLE, operation_status};
         `FCS_REG_IDENT:    next_rdata = {part_code, maker_code};
         `FCS_REG_IRQ_STAT: next_rdata = {30'h0, irq_stat};
         `FCS_REG_IRQ_MASK: next_rdata = {30'h0, irq_mask};
         default:           rd_mapped  = 1'b0;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= rd_mapped ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Current bus cycle and its end
   assign step      = op_step(op, idx, alt_setup);
   assign step_end  = state == fcs_pkg::ST_RECOVER && cnt == 8'h00;
   assign rd_status = f_dq_in[7:0] & `FCS_SR_RSVD_MASK;

   // Operation sequencer: setup, strobe, recover per bus cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state     <= fcs_pkg::ST_IDLE;
         op        <= fcs_pkg::OP_READ_ARRAY;
         alt_setup <= 1'b0;
         idx       <= 2'd0;
         cnt       <= 8'h00;
      end else begin
         case (state)
            fcs_pkg::ST_IDLE: begin
               if (start) begin
                  op        <= fcs_pkg::fcs_op_e'(w_data[`FCS_CTRL_OP_MSB:0]);
                  alt_setup <= w_data[`FCS_CTRL_ALT];
                  idx       <= 2'd0;
                  state     <= fcs_pkg::ST_SETUP;
               end
            end
            fcs_pkg::ST_SETUP: begin
               cnt   <= step.rd ? RD_CYC - 8'h01 : WE_CYC - 8'h01;
               state <= fcs_pkg::ST_STROBE;
            end
            fcs_pkg::ST_STROBE: begin
               if (cnt == 8'h00) begin
                  cnt   <= REC_CYC - 8'h01;
                  state <= fcs_pkg::ST_RECOVER;
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            fcs_pkg::ST_RECOVER: begin
               if (cnt != 8'h00) begin
                  cnt <= cnt - 8'h01;
               end else if (step.poll && !operation_status[`FCS_SR_READY]) begin
                  state <= fcs_pkg::ST_SETUP;
               end else if (step.last) begin
                  state <= fcs_pkg::ST_IDLE;
               end else begin
                  idx   <= idx + 2'd1;
                  state <= fcs_pkg::ST_SETUP;
               end
            end
            default: state <= fcs_pkg::ST_IDLE;
         endcase
      end
   end

   // Flash pins; upper byte driven low on command writes, program data writes drive data_reg[15:0]
   // defined upper byte
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         f_ce_n    <= 1'b1;
         f_oe_n    <= 1'b1;
         f_we_n    <= 1'b1;
         f_dq_oe_n <= 1'b1;
         f_dq_out  <= 16'h0000;
         f_addr    <= '0;
      end else begin
         f_ce_n    <= !(state == fcs_pkg::ST_SETUP || state == fcs_pkg::ST_STROBE) ||
                      (state == fcs_pkg::ST_STROBE && cnt == 8'h00);
         f_oe_n    <= !(state == fcs_pkg::ST_SETUP && step.rd) &&
                      !(state == fcs_pkg::ST_STROBE && step.rd && cnt != 8'h00);
         f_we_n    <= !(state == fcs_pkg::ST_SETUP && !step.rd) &&
                      !(state == fcs_pkg::ST_STROBE && !step.rd && cnt != 8'h00);
         f_dq_oe_n <= step.rd || state == fcs_pkg::ST_IDLE;
         f_dq_out  <= step.use_data ? data_reg[15:0] : {8'h00, step.code};
         f_addr    <= (op == fcs_pkg::OP_IDENT && step.rd) ?
                      {addr_reg[ADDR_W-1:1], step.a0} : addr_reg[ADDR_W-1:0];
      end
   end

   // Read capture at end of the strobe; a fresh strobe per status read
   // sample per toggle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         operation_status <= 8'h00;
         maker_code       <= 16'h0000;
         part_code        <= 16'h0000;
      end else if (state == fcs_pkg::ST_STROBE && cnt == 8'h00 && step.rd) begin
         if (op == fcs_pkg::OP_IDENT && !step.a0) maker_code <= f_dq_in;
         else if (op == fcs_pkg::OP_IDENT) part_code <= f_dq_in;
         else operation_status <= rd_status;
      end
   end

   // Completion and failure events; errors judged only when ready
   // accumulated flags reported
   assign op_done = step_end && step.last && !(step.poll && !operation_status[`FCS_SR_READY]);
   assign op_fail = op_done && step.rd && op != fcs_pkg::OP_IDENT &&
                    operation_status[`FCS_SR_READY] &&
                    (operation_status & `FCS_SR_ERR_MASK) != 8'h00;

   // Sticky interrupt status, write one to clear, set wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat <= 2'h0;
      end else begin
         irq_stat <= (irq_stat & ~((wr_fire && aw_addr == `FCS_REG_IRQ_STAT) ?
                                   w_data[1:0] & {2{w_strb[0]}} : 2'h0)) | {op_fail, op_done};
      end
   end

   assign irq = |(irq_stat & irq_mask);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_wr_strobe;
      $fell(f_we_n);
   endsequence
   sequence s_rd_strobe;
      $fell(f_oe_n);
   endsequence

   a_clear_code: assert property (s_wr_strobe and (op == fcs_pkg::OP_CLEAR) |->
                                  f_dq_out[7:0] == 8'h50) else $error("clear code wrong");
   a_ident_order: assert property (s_rd_strobe and (op == fcs_pkg::OP_IDENT) |->
                                   f_addr[0] == (idx == 2'd2)) else $error("ident a0 wrong");
   a_status_code: assert property (s_wr_strobe and (op == fcs_pkg::OP_STATUS) |->
                                   f_dq_out[7:0] == 8'h70 ##1 !f_we_n[*8])
      else $error("status command wrong");
   a_prog_setup: assert property (s_wr_strobe and (op == fcs_pkg::OP_PROGRAM) and
                                  (idx == 2'd0) |-> f_dq_out[7:0] == 8'h40 ||
                                  f_dq_out[7:0] == 8'h10) else $error("program setup wrong");
   a_erase_pair: assert property (s_wr_strobe and (op == fcs_pkg::OP_ERASE) and
                                  (idx == 2'd1) |-> f_dq_out[7:0] == 8'hd0 &&
                                  f_addr == addr_reg[ADDR_W-1:0]) else $error("erase confirm");
   a_upper_byte: assert property (!f_we_n |-> !f_dq_oe_n && !f_ce_n &&
                                  (f_dq_out[15:8] == 8'h00 || op == fcs_pkg::OP_PROGRAM))
      else $error("write drive wrong");
   a_ready_first: assert property ($rose(irq_stat[1]) |->
                                   operation_status[7] && irq_stat[0]) else $error("fail early");
   a_rsvd_mask: assert property (operation_status[2:0] == 3'h0)
      else $error("reserved bits kept");
   a_read_toggle: assert property (step_end |-> f_oe_n && f_we_n && f_ce_n)
      else $error("no toggle between cycles");
endmodule // fcs_host

// ---- rtl/fcs_pkg.sv ----
// Types shared by the flash command host
package fcs_pkg;
   typedef enum logic [2:0] {
      OP_READ_ARRAY = 3'h0,
      OP_IDENT      = 3'h1,
      OP_STATUS     = 3'h2,
      OP_CLEAR      = 3'h3,
      OP_PROGRAM    = 3'h4,
      OP_ERASE      = 3'h5,
      OP_SUSPEND    = 3'h6,
      OP_RESUME     = 3'h7
   } fcs_op_e;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0001,
      ST_SETUP   = 4'b0010,
      ST_STROBE  = 4'b0100,
      ST_RECOVER = 4'b1000
   } fcs_state_e;

   typedef struct packed {
      logic       rd;       // Read cycle instead of write
      logic       poll;     // Repeat read until device ready
      logic       last;     // Final bus cycle of the operation
      logic       use_data; // Drive program value instead of code
      logic       a0;       // Address bit 0 for identifier reads
      logic [7:0] code;     // Command code on low data byte
   } fcs_step_s;
endpackage

// ---- tb/fcs_flash_model.sv ----
// Behavioural flash device answering the host's bus cycles
`timescale 1ns/100ps
module fcs_flash_model #(
   parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
   parameter logic [15:0] PART_CODE  = 16'h005c  // Arbitrary value
) (
   input  wire logic [16:0] f_addr,
   input  wire logic        f_ce_n,
   input  wire logic        f_oe_n,
   input  wire logic        f_we_n,
   input  wire logic [15:0] f_dq_out,
   output logic      [15:0] f_dq_in,
   input  wire logic [2:0]  fail_sel,
   input  wire logic [1:0]  busy_reads,
   input  wire logic        rsvd_junk
);
   logic [7:0]  sr = 8'h80;
   logic [7:0]  pend = 8'h00;
   logic        erase_run = 1'b0;
   logic        drv = 1'b0;
   int          mode = 0;
   int          phase = 0;
   int          left = 0;
   logic [15:0] wd[$];
   logic [16:0] wa[$];
   initial f_dq_in = 16'h5a5a;
   // Starts the engine; status mode follows
   task automatic go(input logic er);
      sr[7] = 1'b0;
      mode = 2;
      phase = 0;
      erase_run = er;
      left = busy_reads + 1;
   endtask
   // Write strobe is the overlap of chip and write enable; the host raises both together
   wire wr_act = !f_ce_n && !f_we_n;
   // Command decoder acts when the write strobe ends
   always @(negedge wr_act) begin
      wd.push_back(f_dq_out);
      wa.push_back(f_addr);
      // Second program write carries the value
      if (phase == 1) begin
         pend = {3'h0, fail_sel[0], fail_sel[2], 3'h0};
         go(1'b0);
      // Confirm starts erase, anything else fails
      end else if (phase == 2) begin
         mode = 2;
         phase = 0;
         if (f_dq_out[7:0] == 8'hd0) begin
            pend = {2'h0, fail_sel[1] | fail_sel[2], 1'b0, fail_sel[2], 3'h0};
            go(1'b1);
         end else begin
            sr[5:4] = 2'h3;
         end
      end else begin
         case (f_dq_out[7:0])
            8'hff: mode = 0;
            8'h90: mode = 1;
            8'h70: mode = 2;
            8'h50: sr[5:3] = 3'h0;
            8'h40, 8'h10: phase = 1;
            8'h20: phase = 2;
            8'hb0: if (erase_run && !sr[7]) sr[7:6] = 2'h3;
            8'hd0: if (sr[6]) sr[7:6] = 2'h0;
            default: ;
         endcase
      end
   end
   // Status captured on the later falling strobe
   always @(negedge f_oe_n or negedge f_ce_n) if (!f_oe_n && !f_ce_n) begin
      #1; // Address of this cycle settles in the same step as the strobe
      if (left > 0 && !sr[6]) left--;
      if (left == 0 && !sr[7] && !sr[6]) begin
         sr = sr | pend;
         sr[7] = 1'b1;
         erase_run = 1'b0;
      end
      drv = 1'b1;
      case (mode)
         1: f_dq_in = f_addr[0] ? PART_CODE : MAKER_CODE;
         2: f_dq_in = {8'h00, sr[7:3], rsvd_junk ? 3'h7 : 3'h0};
         default: f_dq_in = f_addr[15:0] ^ 16'h3c3c;
      endcase
   end
   // Released bus shows the inverse of the last value
   always @(posedge f_oe_n or posedge f_ce_n) if (drv) begin
      drv = 1'b0;
      f_dq_in = ~f_dq_in;
   end
endmodule // fcs_flash_model

// ---- tb/test_flash_command_status_unit.sv ----
// Self-checking bench for the flash command host against a device model
`timescale 1ns/100ps
`include "fcs_cfg.svh"
module test_flash_command_status_unit;
   localparam logic [15:0] MAKER = 16'h00a5; // Arbitrary value
   localparam logic [15:0] PART  = 16'h005c; // Arbitrary value
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, rsvd_junk = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, busy_reads = '0;
   logic [16:0] f_addr, paddr = '0;
   logic        f_ce_n, f_oe_n, f_we_n, f_dq_oe_n, mask_on = 1'b0;
   logic [15:0] f_dq_out, f_dq_in, pdata = 16'hffff, lfsr = 16'h0024;
   logic [2:0]  fail_sel = '0;
   logic [7:0]  exp_err = '0;
   logic [31:0] v;
   int          n_errors = 0, n_checks = 0, cyc = 0;
   fcs_host i_fcs_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .f_addr, .f_ce_n, .f_oe_n, .f_we_n,
      .f_dq_out, .f_dq_oe_n, .f_dq_in);
   fcs_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_fcs_flash_model (.f_addr,
      .f_ce_n, .f_oe_n, .f_we_n, .f_dq_out, .f_dq_in, .fail_sel, .busy_reads, .rsvd_junk);
   // Clock and hang guard
   always #2.5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         complete_run();
      end
   end
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Write with address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic da, dw;
      da = 1'b0;
      dw = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(da && dw)) begin
         @(negedge aclk);
         da = da | (s_axi_awvalid & s_axi_awready);
         dw = dw | (s_axi_wvalid & s_axi_wready);
         @(posedge aclk);
         if (da) s_axi_awvalid <= 1'b0;
         if (dw) s_axi_wvalid <= 1'b0;
      end
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      chk({30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask
   // One host operation, compared with the reference; the fail flag and write addresses only for program and erase
   task automatic run_op(input logic [2:0] op, input logic alt, input logic [2:0] fs);
      logic [15:0] q[$];
      logic [31:0] r;
      logic        pe;
      pe = (op == 3'h4 || op == 3'h5);
      lfsr = nxt(lfsr);
      fail_sel <= fs;
      busy_reads <= lfsr[1:0];
      rsvd_junk <= lfsr[2];
      i_fcs_flash_model.wd.delete();
      i_fcs_flash_model.wa.delete();
      // Sticky error bits of the reference
      if (op == 3'h3) exp_err = '0;
      if (op == 3'h4) exp_err |= {3'h0, fs[0], fs[2], 3'h0};
      if (op == 3'h5) exp_err |= {2'h0, fs[1] | fs[2], 1'b0, fs[2], 3'h0};
      case (op)
         3'h0: q = '{16'h00ff};
         3'h1: q = '{16'h0090};
         3'h2: q = '{16'h0070};
         3'h3: q = '{16'h0050};
         3'h4: q = '{alt ? 16'h0010 : 16'h0040, pdata};
         3'h5: q = '{16'h0020, 16'h00d0};
         3'h6: q = '{16'h00b0, 16'h0070};
         default: q = '{16'h00d0};
      endcase
      wr(`FCS_REG_CTRL, {27'h0, alt, 1'b0, op}, 2'h0);
      r = 32'h100;
      while (r[8]) rd(`FCS_REG_STATUS, r, 2'h0);
      chk(32'(i_fcs_flash_model.wd.size()), 32'(q.size()));
      foreach (q[i]) chk({16'h0, i_fcs_flash_model.wd[i]}, {16'h0, q[i]});
      if (pe) foreach (q[i]) chk({15'h0, i_fcs_flash_model.wa[i]}, {15'h0, paddr});
      if (pe || op == 3'h2 || op == 3'h6) chk(r, {24'h0, 8'h80 | exp_err});
      if (op == 3'h1) begin
         rd(`FCS_REG_IDENT, r, 2'h0);
         chk(r, {PART, MAKER});
      end
      rd(`FCS_REG_IRQ_STAT, r, 2'h0);
      chk(r & {30'h0, pe, 1'b1}, {30'h0, pe && exp_err != 8'h0, 1'b1});
      @(negedge aclk);
      chk({31'h0, irq}, {31'h0, mask_on});
      wr(`FCS_REG_IRQ_STAT, 32'h3, 2'h0);
      @(negedge aclk);
      chk({31'h0, irq}, 32'h0);
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`FCS_REG_DATA, v, 2'h0);
      chk(v, 32'h0000ffff);
      rd(`FCS_REG_IRQ_MASK, v, 2'h0);
      chk(v, 32'h0);
      rd(8'h20, v, 2'h2);
      chk(v, 32'h0);
      wr(8'h1c, 32'h1, 2'h2);
      wr(`FCS_REG_IRQ_MASK, 32'h3, 2'h0);
      mask_on = 1'b1;
      for (int k = 0; k < 8; k++) run_op(3'(k), 1'b0, 3'h0);
      lfsr = nxt(lfsr);
      paddr = {1'b0, lfsr};
      pdata = nxt(lfsr);
      wr(`FCS_REG_ADDR, {15'h0, paddr}, 2'h0);
      wr(`FCS_REG_DATA, {16'h0, pdata}, 2'h0);
      // Failure must survive a later good program, then clear
      run_op(3'h4, 1'b1, 3'h1);
      run_op(3'h4, 1'b0, 3'h0);
      run_op(3'h2, 1'b0, 3'h0);
      run_op(3'h3, 1'b0, 3'h0);
      run_op(3'h2, 1'b0, 3'h0);
      run_op(3'h5, 1'b0, 3'h2);
      run_op(3'h3, 1'b0, 3'h0);
      run_op(3'h5, 1'b0, 3'h4);
      run_op(3'h3, 1'b0, 3'h0);
      run_op(3'h5, 1'b0, 3'h0);
      wr(`FCS_REG_IRQ_MASK, 32'h0, 2'h0);
      mask_on = 1'b0;
      run_op(3'h0, 1'b0, 3'h0);
      complete_run();
   end
endmodule // test_flash_command_status_unit
